// file: rtl/iemu_pkg.sv
// Package for the integer execution and multiply/divide unit.
package iemu_pkg;
    localparam int unsigned XLEN      = 64;
    localparam int unsigned NREGS     = 32;
    localparam int unsigned RIDX_W    = 5;
    localparam int unsigned CNT_W     = 7;
    localparam int unsigned HALF_W    = 32;
    localparam int unsigned SMALL_W   = 16;
    // Latencies, repeat rates and direct multiply stalls in pipeline clocks.
    localparam logic [6:0] LAT_MUL16  = 7'h03;
    localparam logic [6:0] REP_MUL16  = 7'h02;
    localparam logic [6:0] LAT_MUL32  = 7'h04;
    localparam logic [6:0] REP_MUL32  = 7'h03;
    localparam logic [6:0] STL_DMUL16 = 7'h01;
    localparam logic [6:0] STL_DMUL32 = 7'h02;
    localparam logic [6:0] LAT_WMUL   = 7'h06;
    localparam logic [6:0] REP_WMUL   = 7'h05;
    localparam logic [6:0] LAT_DIV32  = 7'h24;
    localparam logic [6:0] LAT_DIV64  = 7'h44;
    localparam logic [63:0] RESULT_RESET = 64'h0;

    typedef enum logic [3:0] {
        IEMU_ALU_ADD = 4'h0, IEMU_ALU_SUB = 4'h1, IEMU_ALU_AND = 4'h2,
        IEMU_ALU_OR  = 4'h3, IEMU_ALU_XOR = 4'h4, IEMU_ALU_NOR = 4'h5,
        IEMU_ALU_SLL = 4'h6, IEMU_ALU_SRL = 4'h7, IEMU_ALU_SRA = 4'h8,
        IEMU_ALU_SLT = 4'h9, IEMU_ALU_SLTU = 4'ha
    } iemu_alu_op_t;

    typedef enum logic [3:0] {
        IEMU_MD_NONE = 4'h0, IEMU_MD_MUL = 4'h1, IEMU_MD_MAC = 4'h2,
        IEMU_MD_DMUL = 4'h3, IEMU_MD_WMUL = 4'h4, IEMU_MD_DIV = 4'h5,
        IEMU_MD_WDIV = 4'h6, IEMU_MD_MOVE_FROM_HIGH = 4'h7, IEMU_MD_MOVE_FROM_LOW = 4'h8
    } iemu_md_op_t;

    // One issued instruction from the pipeline control.
    typedef struct packed {
        logic         valid;
        iemu_alu_op_t alu_op;
        iemu_md_op_t  md_op;
        logic         is_unsigned;
        logic [4:0]   rs;
        logic [4:0]   rt;
        logic [4:0]   rd;
        logic         wr_en;
        logic         use_imm;
        logic [63:0]  imm;
    } iemu_issue_t;

    typedef enum logic [1:0] {
        IEMU_MD_IDLE = 2'b00, IEMU_MD_BUSY = 2'b01, IEMU_MD_DONE = 2'b11
    } iemu_md_state_t;
endpackage

// file: rtl/iemu_core.sv
// Integer execution datapath with register file and multiply/divide unit.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Thirty-two general registers of 64 bits
// - Two reads, one write, fully bypassed
// - Adder and logic/shift finish in one cycle
// - Multiply/divide results other than direct multiply land in high/low registers
// - Multiply: 3/2 small, 4/3 word
// - Direct multiply writes register, stalls 1/2
// - Wide multiply latency 6, repeat 5
// - Word divide latency and repeat 36
// - Wide divide latency and repeat 68
// - Multiply-add adds product to high:low
// - Operand size picks short timing automatically
// - Interlock stalls overrunning instructions and reads
// - New multiply issues at repeat rate
module iemu_core (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    // Issue port
    input  wire iemu_pkg::iemu_issue_t issue,
    output logic                    stall,
    // Result port
    output logic                    res_valid,
    output logic [4:0]              res_rd,
    output logic [63:0]             res_data,
    output logic [63:0]             high_result_reg,
    output logic [63:0]             low_result_reg
);
    import iemu_pkg::*;

    logic [63:0]    gpr_reg [NREGS];
    logic [63:0]    hi_reg, lo_reg, hi_next, lo_next;
    logic           wb_en;
    logic [4:0]     wb_rd;
    logic [63:0]    wb_data;
    logic [63:0]    opa, opb, alu_res;
    logic [6:0]     busy_cnt_reg, lat_cnt_reg;
    logic [6:0]     lat_sel, rep_sel, stl_sel;
    logic [6:0]     dstall_cnt_reg;
    iemu_md_state_t md_state_reg;
    iemu_md_op_t    md_op_reg;
    logic           md_uns_reg;
    logic [4:0]     md_rd_reg;
    logic [63:0]    md_a_reg, md_b_reg;
    logic           small_ops, go, is_md, md_done;
    logic [127:0]   prod;
    logic [63:0]    quo, rem;
    logic           dmul_wb;
    logic [63:0]    dmul_data;

    // Source read with bypass of a direct multiply finishing this cycle. An instruction's
    // own result is never forwarded, as that would close a combinational loop.
    function automatic logic [63:0] rd_port(input logic [4:0] idx, input logic en,
                                            input logic [4:0] wi, input logic [63:0] wd,
                                            input logic [63:0] rf);
        if (idx == 5'h00) return 64'h0;
        if (en && wi == idx) return wd;
        return rf;
    endfunction

    // True when a value fits in 16 bits under the chosen signedness.
    function automatic logic fits16(input logic [63:0] v, input logic uns);
        if (uns) return v[63:16] == 48'h0;
        return v[63:15] == {49{v[15]}} || v[63:15] == 49'h0;
    endfunction

    assign opa = rd_port(issue.rs, dmul_wb, md_rd_reg, dmul_data, gpr_reg[issue.rs]);
    assign opb = issue.use_imm ? issue.imm
               : rd_port(issue.rt, dmul_wb, md_rd_reg, dmul_data, gpr_reg[issue.rt]);

    // Single-cycle adder and logic/shift unit.
    always_comb begin
        case (issue.alu_op)
            IEMU_ALU_ADD:  alu_res = opa + opb;
            IEMU_ALU_SUB:  alu_res = opa - opb;
            IEMU_ALU_AND:  alu_res = opa & opb;
            IEMU_ALU_OR:   alu_res = opa | opb;
            IEMU_ALU_XOR:  alu_res = opa ^ opb;
            IEMU_ALU_NOR:  alu_res = ~(opa | opb);
            IEMU_ALU_SLL:  alu_res = opa << opb[5:0];
            IEMU_ALU_SRL:  alu_res = opa >> opb[5:0];
            IEMU_ALU_SRA:  alu_res = $signed(opa) >>> opb[5:0];
            IEMU_ALU_SLT:  alu_res = {63'h0, $signed(opa) < $signed(opb)};
            IEMU_ALU_SLTU: alu_res = {63'h0, opa < opb};
            default:       alu_res = 64'h0;
        endcase
    end

    assign is_md = issue.md_op inside {IEMU_MD_MUL, IEMU_MD_MAC, IEMU_MD_DMUL,
                                       IEMU_MD_WMUL, IEMU_MD_DIV, IEMU_MD_WDIV};
    assign small_ops = fits16(opa, issue.is_unsigned) && fits16(opb, issue.is_unsigned);

    always_comb begin
        stl_sel = 7'h00;
        case (issue.md_op)
            IEMU_MD_MUL, IEMU_MD_MAC, IEMU_MD_DMUL: begin
                lat_sel = small_ops ? LAT_MUL16 : LAT_MUL32;
                rep_sel = small_ops ? REP_MUL16 : REP_MUL32;
                if (issue.md_op == IEMU_MD_DMUL) begin
                    stl_sel = small_ops ? STL_DMUL16 : STL_DMUL32;
                end
            end
            IEMU_MD_WMUL: begin
                lat_sel = LAT_WMUL;
                rep_sel = REP_WMUL;
            end
            IEMU_MD_DIV: begin
                lat_sel = LAT_DIV32;
                rep_sel = LAT_DIV32;
            end
            IEMU_MD_WDIV: begin
                lat_sel = LAT_DIV64;
                rep_sel = LAT_DIV64;
            end
            default: begin
                lat_sel = 7'h00;
                rep_sel = 7'h00;
            end
        endcase
    end

    // Interlock: a new operation waits for the repeat window, result reads wait for
    // the result, and the direct multiply holds the pipe for its stall cycles.
    // A writing instruction also waits while a finishing direct multiply to a nonzero register
    // holds the single write port; beside one that targets register zero its taken write is lost.
    always_comb begin
        stall = 1'b0;
        if (issue.valid) begin
            if (is_md && busy_cnt_reg != 7'h00) stall = 1'b1;
            if (issue.wr_en && dmul_wb) stall = 1'b1;
            if ((issue.md_op == IEMU_MD_MOVE_FROM_HIGH || issue.md_op == IEMU_MD_MOVE_FROM_LOW)
                && md_state_reg == IEMU_MD_BUSY) stall = 1'b1;
        end
        if (dstall_cnt_reg != 7'h00) stall = 1'b1;
    end
    assign go = issue.valid && is_md && !stall;

    // Repeat-rate window counter.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_reg <= 7'h00;
        end else if (go) begin
            busy_cnt_reg <= rep_sel - 7'h01;
        end else if (busy_cnt_reg != 7'h00) begin
            busy_cnt_reg <= busy_cnt_reg - 7'h01;
        end
    end

    // Direct multiply stall counter.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dstall_cnt_reg <= 7'h00;
        end else if (go && issue.md_op == IEMU_MD_DMUL) begin
            dstall_cnt_reg <= stl_sel;
        end else if (dstall_cnt_reg != 7'h00) begin
            dstall_cnt_reg <= dstall_cnt_reg - 7'h01;
        end
    end

    // Operation tracking. The repeat window never ends before the earlier latency minus
    // one, so a new issue lands at the earliest on the edge that commits the earlier result.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            md_state_reg <= IEMU_MD_IDLE;
            lat_cnt_reg  <= 7'h00;
            md_op_reg    <= IEMU_MD_NONE;
            md_uns_reg   <= 1'b0;
            md_rd_reg    <= 5'h00;
            md_a_reg     <= 64'h0;
            md_b_reg     <= 64'h0;
        end else if (go) begin
            md_state_reg <= IEMU_MD_BUSY;
            lat_cnt_reg  <= lat_sel - 7'h01;
            md_op_reg    <= issue.md_op;
            md_uns_reg   <= issue.is_unsigned;
            md_rd_reg    <= issue.rd;
            md_a_reg     <= opa;
            md_b_reg     <= opb;
        end else if (md_state_reg == IEMU_MD_BUSY) begin
            lat_cnt_reg <= lat_cnt_reg - 7'h01;
            if (lat_cnt_reg == 7'h01) begin
                md_state_reg <= IEMU_MD_DONE;
            end
        end else if (md_state_reg == IEMU_MD_DONE) begin
            md_state_reg <= IEMU_MD_IDLE;
        end
    end
    assign md_done   = (md_state_reg == IEMU_MD_BUSY) && (lat_cnt_reg == 7'h01);
    assign dmul_wb   = md_done && md_op_reg == IEMU_MD_DMUL && md_rd_reg != 5'h00;
    assign dmul_data = {{32{prod[31]}}, prod[31:0]};

    // Arithmetic on the captured operands; word operations use the low halves.
    always_comb begin
        logic [63:0] a32, b32;
        a32 = md_uns_reg ? {32'h0, md_a_reg[31:0]} : {{32{md_a_reg[31]}}, md_a_reg[31:0]};
        b32 = md_uns_reg ? {32'h0, md_b_reg[31:0]} : {{32{md_b_reg[31]}}, md_b_reg[31:0]};
        quo = 64'h0;
        rem = 64'h0;
        if (md_op_reg == IEMU_MD_WMUL || md_op_reg == IEMU_MD_WDIV) begin
            a32 = md_a_reg;
            b32 = md_b_reg;
        end
        if (md_uns_reg) begin
            prod = {64'h0, a32} * {64'h0, b32};
        end else begin
            prod = 128'($signed({{64{a32[63]}}, a32}) * $signed({{64{b32[63]}}, b32}));
        end
        if (b32 != 64'h0) begin
            if (md_uns_reg) begin
                quo = a32 / b32;
                rem = a32 % b32;
            end else begin
                quo = 64'($signed(a32) / $signed(b32));
                rem = 64'($signed(a32) % $signed(b32));
            end
        end
    end

    always_comb begin
        hi_next = hi_reg;
        lo_next = lo_reg;
        case (md_op_reg)
            IEMU_MD_MUL: begin
                hi_next = {{32{prod[63]}}, prod[63:32]};
                lo_next = {{32{prod[31]}}, prod[31:0]};
            end
            IEMU_MD_MAC: begin
                hi_next = 64'({hi_reg[31:0], lo_reg[31:0]} + prod[63:0]) >> 32;
                lo_next = {32'h0, 32'({hi_reg[31:0], lo_reg[31:0]} + prod[63:0])};
                hi_next = {{32{hi_next[31]}}, hi_next[31:0]};
                lo_next = {{32{lo_next[31]}}, lo_next[31:0]};
            end
            IEMU_MD_WMUL: begin
                hi_next = prod[127:64];
                lo_next = prod[63:0];
            end
            IEMU_MD_DIV: begin
                hi_next = {{32{rem[31]}}, rem[31:0]};
                lo_next = {{32{quo[31]}}, quo[31:0]};
            end
            IEMU_MD_WDIV: begin
                hi_next = rem;
                lo_next = quo;
            end
            default: ;
        endcase
    end

    // The direct multiply bypasses the result registers entirely.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_reg <= RESULT_RESET;
            lo_reg <= RESULT_RESET;
        end else if (md_done && md_op_reg != IEMU_MD_DMUL) begin
            hi_reg <= hi_next;
            lo_reg <= lo_next;
        end
    end
    assign high_result_reg = hi_reg;
    assign low_result_reg  = lo_reg;

    // Write-back selection: a finishing direct multiply takes the write port.
    always_comb begin
        wb_en   = 1'b0;
        wb_rd   = issue.rd;
        wb_data = alu_res;
        if (md_done && md_op_reg == IEMU_MD_DMUL) begin
            wb_en   = md_rd_reg != 5'h00;
            wb_rd   = md_rd_reg;
            wb_data = {{32{prod[31]}}, prod[31:0]};
        end else if (issue.valid && !stall && issue.wr_en && issue.rd != 5'h00) begin
            wb_en = 1'b1;
            if (issue.md_op == IEMU_MD_MOVE_FROM_HIGH) wb_data = hi_reg;
            else if (issue.md_op == IEMU_MD_MOVE_FROM_LOW) wb_data = lo_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wb_en) gpr_reg[wb_rd] <= wb_data;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            res_valid <= 1'b0;
            res_rd    <= 5'h00;
            res_data  <= 64'h0;
        end else begin
            res_valid <= wb_en;
            res_rd    <= wb_rd;
            res_data  <= wb_data;
        end
    end

    AST_REPEAT_BLOCKS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_WMUL
        |=> (busy_cnt_reg != 7'h00)[*4] ##1 busy_cnt_reg == 7'h00)
        else $error("wide multiply repeat window wrong");
    AST_DIV_LAT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_DIV |-> ##35 md_done)
        else $error("divide latency wrong");
    AST_WDIV_LAT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_WDIV |-> ##67 md_done)
        else $error("wide divide latency wrong");
    AST_MUL_LAT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_MUL && small_ops |-> ##2 md_done)
        else $error("small multiply latency wrong");
    AST_WMUL_LAT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_WMUL |-> ##5 md_done)
        else $error("wide multiply latency wrong");
    AST_DMUL_STALL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_DMUL && !small_ops |=> stall[*2])
        else $error("direct multiply stall too short");
    AST_READ_INTERLOCK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        issue.valid && issue.md_op == IEMU_MD_MOVE_FROM_LOW && md_state_reg == IEMU_MD_BUSY |-> stall)
        else $error("result read not interlocked");
    AST_RESULT_REGS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        md_done && md_op_reg == IEMU_MD_WMUL |=> lo_reg == $past(prod[63:0]))
        else $error("low result not written");
    AST_BYPASS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        dmul_wb && issue.valid && issue.rs == md_rd_reg
        |=> gpr_reg[$past(md_rd_reg)] == $past(opa))
        else $error("bypass missing");

    COV_MAC: cover property (@(posedge ref_clk) disable iff (!arst_n)
        go && issue.md_op == IEMU_MD_MAC);
    COV_DMUL: cover property (@(posedge ref_clk) disable iff (!arst_n)
        md_done && md_op_reg == IEMU_MD_DMUL);
    COV_BACK2BACK: cover property (@(posedge ref_clk) disable iff (!arst_n)
        go ##2 go);
endmodule
`default_nettype wire

// file: verif/iemu_issue_model.sv
// Behavioural issue stage that feeds the execution unit and honours its stall.
`timescale 1ns/1ns
`default_nettype none
module iemu_issue_model (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    // Issue handshake
    input  wire logic                  stall,
    output var iemu_pkg::iemu_issue_t  issue
);
    import iemu_pkg::*;

    iemu_issue_t pend [$];
    int          takes [$];
    int          cyc_reg;

    task automatic push(input iemu_issue_t x);
        pend.push_back(x);
    endtask

    // An idle slot shows the inverted last word, so nothing can lean on stale fields.
    always @(posedge ref_clk or negedge arst_n) begin : issue_seq
        iemu_issue_t nx;
        if (!arst_n) begin
            issue <= '0;
            cyc_reg <= 0;
        end else begin
            cyc_reg <= cyc_reg + 1;
            if (issue.valid && !stall) begin
                takes.push_back(cyc_reg);
            end
            if (!issue.valid || !stall) begin
                nx = ~issue;
                nx.valid = 1'b0;
                if (pend.size() > 0) begin
                    nx = pend.pop_front();
                end
                issue <= nx;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking testbench for the integer execution and multiply/divide unit.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import iemu_pkg::*;

    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    iemu_issue_t issue;
    logic        stall;
    logic        res_valid;
    logic [4:0]  res_rd;
    logic [63:0] res_data;
    logic [63:0] high_result_reg;
    logic [63:0] low_result_reg;
    logic [63:0] rdat [32];
    int          redge [32];
    logic [63:0] ehi = RESULT_RESET;
    logic [63:0] elo = RESULT_RESET;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #20 ref_clk = ~ref_clk;

    iemu_core iemu_core_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .issue(issue), .stall(stall),
        .res_valid(res_valid), .res_rd(res_rd), .res_data(res_data),
        .high_result_reg(high_result_reg), .low_result_reg(low_result_reg)
    );

    iemu_issue_model iemu_issue_model_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .stall(stall), .issue(issue)
    );

    // Results are logged per destination with the cycle in which they stand.
    always @(negedge ref_clk) begin
        if (res_valid === 1'b1) begin
            rdat[res_rd] = res_data;
            redge[res_rd] = iemu_issue_model_i.cyc_reg;
        end
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic iemu_issue_t mk(iemu_alu_op_t a, iemu_md_op_t m, logic u, logic [4:0] s,
                                       logic [4:0] t, logic [4:0] d, logic w, logic [63:0] im);
        return '{1'b1, a, m, u, s, t, d, w, (m == IEMU_MD_NONE), im};
    endfunction

    // Waits for take number n; the bound keeps a wedged stall from hanging the run.
    task automatic wt(input int n, output int t);
        int k;
        k = 0;
        while (iemu_issue_model_i.takes.size() <= n && k < 200) begin
            @(negedge ref_clk);
            k++;
        end
        `CHK(k < 200, 1'b1)
        t = (k < 200) ? iemu_issue_model_i.takes[n] : 0;
    endtask

    task automatic alu_run(input iemu_alu_op_t op, input logic [4:0] s, input logic [63:0] im,
                           input logic [4:0] d, input logic [63:0] exp);
        int b;
        int t;
        b = iemu_issue_model_i.takes.size();
        rdat[d] = 'x;
        iemu_issue_model_i.push(mk(op, IEMU_MD_NONE, 1'b0, s, 5'h00, d, 1'b1, im));
        wt(b, t);
        repeat (2) @(negedge ref_clk);
        `CHK(rdat[d], exp)
        `CHK(redge[d] - t, 1)
    endtask

    task automatic alu_table();
        alu_run(IEMU_ALU_SUB, 5'h03, 64'h4, 5'h14, 64'h12341);
        alu_run(IEMU_ALU_AND, 5'h03, 64'h4, 5'h14, 64'h4);
        alu_run(IEMU_ALU_OR, 5'h03, 64'h4, 5'h14, 64'h12345);
        alu_run(IEMU_ALU_XOR, 5'h03, 64'h4, 5'h14, 64'h12341);
        alu_run(IEMU_ALU_NOR, 5'h03, 64'h4, 5'h14, 64'hffff_ffff_fffe_dcba);
        alu_run(IEMU_ALU_SLL, 5'h03, 64'h4, 5'h14, 64'h123450);
        alu_run(IEMU_ALU_SRL, 5'h03, 64'h4, 5'h14, 64'h1234);
        alu_run(IEMU_ALU_SRA, 5'h02, 64'h4, 5'h14, 64'hffff_ffff_ffff_ffff);
        alu_run(IEMU_ALU_SLT, 5'h02, 64'h4, 5'h14, 64'h1);
        alu_run(IEMU_ALU_SLTU, 5'h02, 64'h4, 5'h14, 64'h0);
    endtask

    // A write to register zero, then a chain whose second step reads the first one's result.
    task automatic bypass_chain();
        int b;
        int t;
        b = iemu_issue_model_i.takes.size();
        rdat[6] = 'x;
        rdat[31] = 'x;
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_NONE, 1'b0, 5'h00, 5'h00, 5'h00, 1'b1,
                                   64'h55));
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_NONE, 1'b0, 5'h00, 5'h00, 5'h1f, 1'b1,
                                   64'h11));
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_NONE, 1'b0, 5'h1f, 5'h00, 5'h06, 1'b1,
                                   64'h22));
        wt(b + 2, t);
        repeat (2) @(negedge ref_clk);
        `CHK(t - iemu_issue_model_i.takes[b], 2)
        `CHK(rdat[31], 64'h11)
        `CHK(rdat[6], 64'h33)
    endtask

    // Two like operations back to back, then both moves, which must wait for the second.
    task automatic md_run(input iemu_md_op_t op, input logic u, input logic [4:0] a,
                          input logic [4:0] c, input int lat, input int rep,
                          input logic [63:0] nh, input logic [63:0] nl,
                          input logic [63:0] fh, input logic [63:0] fl);
        int b;
        int t0;
        int t1;
        b = iemu_issue_model_i.takes.size();
        rdat[8] = 'x;
        rdat[9] = 'x;
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, op, u, a, c, 5'h00, 1'b0, 64'h0));
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, op, u, a, c, 5'h00, 1'b0, 64'h0));
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_MOVE_FROM_LOW, 1'b0, 5'h00, 5'h00, 5'h09, 1'b1,
                                   64'h0));
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_MOVE_FROM_HIGH, 1'b0, 5'h00, 5'h00, 5'h08, 1'b1,
                                   64'h0));
        wt(b, t0);
        repeat (lat - 2) @(negedge ref_clk);
        `CHK({high_result_reg, low_result_reg}, {ehi, elo})
        @(negedge ref_clk);
        `CHK({high_result_reg, low_result_reg}, {nh, nl})
        wt(b + 1, t1);
        `CHK(t1 - t0, rep)
        wt(b + 3, t1);
        repeat (2) @(negedge ref_clk);
        `CHK({rdat[8], rdat[9]}, {fh, fl})
        ehi = fh;
        elo = fl;
    endtask

    task automatic direct_mul(input logic [4:0] a, input logic [4:0] c, input int lat,
                              input int stl, input logic [63:0] exp);
        int b;
        int t0;
        int t1;
        b = iemu_issue_model_i.takes.size();
        rdat[10] = 'x;
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_DMUL, 1'b0, a, c, 5'h0a, 1'b1, 64'h0));
        iemu_issue_model_i.push(mk(IEMU_ALU_ADD, IEMU_MD_NONE, 1'b0, 5'h0a, 5'h00, 5'h0c, 1'b0,
                                   64'h1));
        wt(b, t0);
        wt(b + 1, t1);
        `CHK(t1 - t0, stl + 1)
        repeat (lat + 2) @(negedge ref_clk);
        `CHK(rdat[10], exp)
        `CHK(redge[10] - t0, lat)
        `CHK(low_result_reg, elo)
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        `CHK({high_result_reg, low_result_reg}, {ehi, elo})
        alu_run(IEMU_ALU_ADD, 5'h00, 64'h5, 5'h01, 64'h5);
        alu_run(IEMU_ALU_ADD, 5'h00, 64'hffff_ffff_ffff_fffd, 5'h02,
                64'hffff_ffff_ffff_fffd);
        alu_run(IEMU_ALU_ADD, 5'h00, 64'h12345, 5'h03, 64'h12345);
        alu_run(IEMU_ALU_ADD, 5'h00, 64'h7, 5'h04, 64'h7);
        alu_table();
        bypass_chain();
        md_run(IEMU_MD_MUL, 1'b0, 5'h01, 5'h02, 3, 2, 64'hffff_ffff_ffff_ffff,
               64'hffff_ffff_ffff_fff1, 64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_fff1);
        md_run(IEMU_MD_MUL, 1'b1, 5'h01, 5'h02, 4, 3, 64'h4, 64'hffff_ffff_ffff_fff1,
               64'h4, 64'hffff_ffff_ffff_fff1);
        md_run(IEMU_MD_MUL, 1'b1, 5'h03, 5'h04, 4, 3, 64'h0, 64'h7f6e3, 64'h0, 64'h7f6e3);
        md_run(IEMU_MD_MAC, 1'b0, 5'h01, 5'h02, 3, 2, 64'h0, 64'h7f6d4, 64'h0, 64'h7f6c5);
        md_run(IEMU_MD_WMUL, 1'b0, 5'h02, 5'h03, 6, 5, 64'hffff_ffff_ffff_ffff,
               64'hffff_ffff_fffc_9631, 64'hffff_ffff_ffff_ffff, 64'hffff_ffff_fffc_9631);
        md_run(IEMU_MD_DIV, 1'b1, 5'h03, 5'h04, 36, 36, 64'h1, 64'h299c, 64'h1, 64'h299c);
        md_run(IEMU_MD_WDIV, 1'b0, 5'h02, 5'h01, 68, 68, 64'hffff_ffff_ffff_fffd, 64'h0,
               64'hffff_ffff_ffff_fffd, 64'h0);
        direct_mul(5'h01, 5'h02, 3, 1, 64'hffff_ffff_ffff_fff1);
        direct_mul(5'h03, 5'h04, 4, 2, 64'h7f6e3);
        finish_test();
    end
endmodule
`default_nettype wire
